// >>> src/dco_pkg.sv
`default_nettype none
package dco_pkg;
    // Object dictionary layout
    localparam logic [15:0] DCO_PAR_BASE      = 16'h2000;
    localparam logic [15:0] DCO_CTL_INDEX     = 16'h2020;
    localparam logic [15:0] DCO_STS_INDEX     = 16'h2021;
    localparam int          DCO_GROUP_W       = 5;
    localparam logic [7:0]  DCO_SUB_OFFSET    = 8'h01;
    localparam logic [7:0]  DCO_SUB_COUNT     = 8'h00;
    localparam logic [7:0]  DCO_SUB_CTL_WORD  = 8'h01;
    localparam logic [7:0]  DCO_SUB_FREQ      = 8'h02;
    localparam logic [7:0]  DCO_SUB_TRIG      = 8'h03;
    localparam logic [7:0]  DCO_SUB_FAULT     = 8'h01;
    localparam logic [7:0]  DCO_SUB_STATE     = 8'h02;
    // Reset values
    localparam logic [7:0]  DCO_CTL_COUNT_RST = 8'h03;
    localparam logic [7:0]  DCO_STS_COUNT_RST = 8'h0a;
    localparam logic [15:0] DCO_WORD_RST      = 16'h0000;
    // Command word fields
    localparam int          DCO_CW_RUN_LSB    = 0;
    localparam int          DCO_CW_DIR_LSB    = 4;
    localparam int          DCO_CW_ACC_LSB    = 6;
    localparam int          DCO_CW_STEP_LSB   = 8;
    localparam int          DCO_CW_SEL_EN     = 12;
    localparam int          DCO_CW_SRC_LSB    = 13;
    // Trigger fields
    localparam int          DCO_TR_EXT_FAULT  = 0;
    localparam int          DCO_TR_RESET      = 1;
    localparam int          DCO_TR_BLOCK      = 2;
    // State word fields
    localparam int          DCO_SW_RUN_LSB    = 0;
    localparam int          DCO_SW_INCH       = 2;
    localparam int          DCO_SW_DIR_LSB    = 3;
    localparam int          DCO_SW_FREQ_COMM  = 8;
    localparam int          DCO_SW_FREQ_ANA   = 9;

    typedef enum logic [1:0] {DCO_RUN_NONE, DCO_RUN_STOP, DCO_RUN_GO, DCO_RUN_INCH}          dco_run_type;
    typedef enum logic [1:0] {DCO_DIR_NONE, DCO_DIR_FWD, DCO_DIR_REV, DCO_DIR_CHANGE}        dco_dir_type;
    typedef enum logic [1:0] {DCO_SRC_NONE, DCO_SRC_KEYPAD, DCO_SRC_PARAM, DCO_SRC_TOGGLE}   dco_src_type;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] index;
        logic [7:0]  sub;
        logic [15:0] wdata;
    } dco_req_type;

    typedef struct packed {
        logic        valid;
        logic        ok;
        logic [15:0] rdata;
    } dco_rsp_type;

    typedef struct packed {
        logic                   valid;
        logic                   write;
        logic [DCO_GROUP_W-1:0] group;
        logic [7:0]             member;
        logic [15:0]            wdata;
    } dco_par_type;

    typedef struct packed {
        logic [1:0]  run_state;
        logic        inch_run;
        logic [1:0]  dir_state;
        logic        freq_comm;
        logic        freq_analog;
        logic [15:0] fault_code;
    } dco_drv_type;

    typedef struct packed {
        logic        strobe;
        dco_run_type run;
        dco_dir_type dir;
        logic [1:0]  accel_set;
        logic [3:0]  speed_step;
        logic        keypad_src;
        logic [15:0] speed_ref;
        logic        ext_fault;
        logic        fault_reset;
        logic        base_block;
    } dco_cmd_type;
endpackage : dco_pkg
`default_nettype wire

// >>> src/dco_word_decode.sv
`default_nettype none
module dco_word_decode
    import dco_pkg::*;
(
    input  wire logic [15:0] i_word,
    input  wire logic [1:0]  i_accel_set,
    input  wire logic [3:0]  i_speed_step,
    input  wire logic        i_keypad_src,
    output logic      [1:0]  o_accel_set,
    output logic      [3:0]  o_speed_step,
    output logic             o_keypad_src
);
    dco_src_type src_code;

    always_comb begin
        src_code = dco_src_type'(i_word[DCO_CW_SRC_LSB +: 2]);
        if (i_word[DCO_CW_SEL_EN]) begin  // RULE4
            o_accel_set  = i_word[DCO_CW_ACC_LSB +: 2];  // RULE2
            o_speed_step = i_word[DCO_CW_STEP_LSB +: 4];  // RULE3
        end else begin
            o_accel_set  = i_accel_set;
            o_speed_step = i_speed_step;
        end
        unique case (src_code)  // RULE5
            DCO_SRC_NONE:   o_keypad_src = i_keypad_src;
            DCO_SRC_KEYPAD: o_keypad_src = 1'b1;
            DCO_SRC_PARAM:  o_keypad_src = 1'b0;
            DCO_SRC_TOGGLE: o_keypad_src = ~i_keypad_src;
        endcase
    end
endmodule : dco_word_decode
`default_nettype wire

// >>> src/dco_object_decoder.sv
// Overview of operation
// RULE1: Parameter G.M at 0x2000+G, sub M+1
// RULE2: Word bits 7-6 pick accel set
// RULE3: Word bits 11-8 pick master or step speed
// RULE4: Bit 12 enables accel and step fields
// RULE5: Bits 14-13 pick, keep or toggle source
// RULE6: Speed reference: RW 16-bit, 0.01 Hz, zero
// RULE7: Trigger bits: external fault, reset, block
// RULE8: State bits 1-0 report run state
// RULE9: State bits 4-3 direction, bit 2 inch
// RULE10: State bit 8 flags comm frequency control
// RULE11: State bit 9 flags analog frequency command
// RULE12: Word bits 1-0 run, 5-4 direction
`default_nettype none
module dco_object_decoder
    import dco_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_reset,
    input  wire dco_req_type i_req,
    input  wire dco_rsp_type i_par_rsp,
    input  wire dco_drv_type i_drv,
    output var  dco_rsp_type o_rsp,
    output var  dco_par_type o_par,
    output var  dco_cmd_type o_cmd
);
    logic [15:0] ctl_word_q;
    logic [15:0] trig_q;
    logic [15:0] state_q;
    logic [15:0] fault_q;
    dco_rsp_type rsp_q;
    dco_par_type par_q;
    dco_cmd_type cmd_q;
    logic [1:0]  accel_d;
    logic [3:0]  step_d;
    logic        keypad_d;
    logic        par_hit;
    logic        wr_word;
    logic        wr_freq;
    logic        wr_trig;

    function automatic logic is_param(input logic [15:0] index);
        return (index >= DCO_PAR_BASE) && (index < DCO_CTL_INDEX);
    endfunction : is_param

    function automatic logic is_write(input dco_req_type req, input logic [7:0] sub);
        return req.valid && req.write && (req.index == DCO_CTL_INDEX) && (req.sub == sub);
    endfunction : is_write

    function automatic dco_rsp_type obj_read(input dco_req_type req, input logic [15:0] word,
                                             input logic [15:0] freq, input logic [15:0] trig,
                                             input logic [15:0] fault, input logic [15:0] state);
        dco_rsp_type r;
        r.valid = 1'b1;
        r.ok    = 1'b1;
        r.rdata = DCO_WORD_RST;
        if (req.index == DCO_CTL_INDEX) begin
            unique case (req.sub)
                DCO_SUB_COUNT:    r.rdata = {8'h00, DCO_CTL_COUNT_RST};
                DCO_SUB_CTL_WORD: r.rdata = word;
                DCO_SUB_FREQ:     r.rdata = freq;
                DCO_SUB_TRIG:     r.rdata = trig;
                default:          r.ok    = 1'b0;
            endcase
            if (req.write && (req.sub == DCO_SUB_COUNT)) begin
                r.ok = 1'b0;
            end
        end else if (req.index == DCO_STS_INDEX) begin
            unique case (req.sub)
                DCO_SUB_COUNT: r.rdata = {8'h00, DCO_STS_COUNT_RST};
                DCO_SUB_FAULT: r.rdata = fault;
                DCO_SUB_STATE: r.rdata = state;
                default:       r.ok    = 1'b0;
            endcase
            if (req.write) begin
                r.ok = 1'b0;
            end
        end else begin
            r.ok = 1'b0;
        end
        return r;
    endfunction : obj_read

    assign par_hit = i_req.valid && is_param(i_req.index) && (i_req.sub != DCO_SUB_COUNT);
    assign wr_word = is_write(i_req, DCO_SUB_CTL_WORD);
    assign wr_freq = is_write(i_req, DCO_SUB_FREQ);
    assign wr_trig = is_write(i_req, DCO_SUB_TRIG);

    dco_word_decode u_word_decode (
        .i_word       (i_req.wdata),
        .i_accel_set  (cmd_q.accel_set),
        .i_speed_step (cmd_q.speed_step),
        .i_keypad_src (cmd_q.keypad_src),
        .o_accel_set  (accel_d),
        .o_speed_step (step_d),
        .o_keypad_src (keypad_d)
    );

    // Parameter forwarding
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            par_q <= '0;
        end else begin
            par_q.valid <= par_hit;
            if (par_hit) begin
                par_q.write  <= i_req.write;
                par_q.group  <= DCO_GROUP_W'(i_req.index - DCO_PAR_BASE);  // RULE1
                par_q.member <= i_req.sub - DCO_SUB_OFFSET;  // RULE1
                par_q.wdata  <= i_req.wdata;
            end
        end
    end

    // Answers
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            rsp_q <= '0;
        end else if (i_req.valid && !par_hit) begin
            rsp_q <= obj_read(i_req, ctl_word_q, cmd_q.speed_ref, trig_q, fault_q, state_q);
        end else if (i_par_rsp.valid) begin
            rsp_q <= i_par_rsp;
        end else begin
            rsp_q.valid <= 1'b0;
        end
    end

    // Stored words
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            ctl_word_q <= DCO_WORD_RST;
            trig_q     <= DCO_WORD_RST;
        end else begin
            if (wr_word) begin
                ctl_word_q <= i_req.wdata;
            end
            if (wr_trig) begin
                trig_q <= i_req.wdata;
            end
        end
    end

    // Command outputs
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            cmd_q <= '0;
        end else begin
            cmd_q.strobe <= wr_word;
            if (wr_word) begin
                cmd_q.run        <= dco_run_type'(i_req.wdata[DCO_CW_RUN_LSB +: 2]);  // RULE12
                cmd_q.dir        <= dco_dir_type'(i_req.wdata[DCO_CW_DIR_LSB +: 2]);  // RULE12
                cmd_q.accel_set  <= accel_d;  // RULE2
                cmd_q.speed_step <= step_d;  // RULE3
                cmd_q.keypad_src <= keypad_d;  // RULE5
            end
            if (wr_freq) begin
                cmd_q.speed_ref <= i_req.wdata;  // RULE6
            end
            if (wr_trig) begin
                cmd_q.ext_fault   <= i_req.wdata[DCO_TR_EXT_FAULT];  // RULE7
                cmd_q.fault_reset <= i_req.wdata[DCO_TR_RESET];  // RULE7
                cmd_q.base_block  <= i_req.wdata[DCO_TR_BLOCK];  // RULE7
            end
        end
    end

    // Drive state capture
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            state_q <= DCO_WORD_RST;
            fault_q <= DCO_WORD_RST;
        end else begin
            state_q                          <= DCO_WORD_RST;
            state_q[DCO_SW_RUN_LSB +: 2]     <= i_drv.run_state;  // RULE8
            state_q[DCO_SW_INCH]             <= i_drv.inch_run;  // RULE9
            state_q[DCO_SW_DIR_LSB +: 2]     <= i_drv.dir_state;  // RULE9
            state_q[DCO_SW_FREQ_COMM]        <= i_drv.freq_comm;  // RULE10
            state_q[DCO_SW_FREQ_ANA]         <= i_drv.freq_analog;  // RULE11
            fault_q                          <= i_drv.fault_code;
        end
    end

    assign o_rsp = rsp_q;
    assign o_par = par_q;
    assign o_cmd = cmd_q;

    // Checks
    logic rd_state;
    logic rd_freq;
    assign rd_state = i_req.valid && !i_req.write && (i_req.index == DCO_STS_INDEX)
                      && (i_req.sub == DCO_SUB_STATE);
    assign rd_freq  = i_req.valid && !i_req.write && (i_req.index == DCO_CTL_INDEX)
                      && (i_req.sub == DCO_SUB_FREQ);

    sequence s_freq_written;
        wr_freq ##1 !wr_freq [*3];
    endsequence

    sequence s_freq_read;
        rd_freq ##1 o_rsp.valid;
    endsequence

    property p_param_map;
        @(posedge i_clk_sys) disable iff (i_reset)
        par_hit |=> o_par.valid && (o_par.group == $past(i_req.index[DCO_GROUP_W-1:0]))
                    && (o_par.member + DCO_SUB_OFFSET == $past(i_req.sub));
    endproperty
    a_param_map: assert property (p_param_map) else $error("Parameter index map wrong");  // RULE1

    property p_accel_take;
        @(posedge i_clk_sys) disable iff (i_reset)
        wr_word && i_req.wdata[DCO_CW_SEL_EN]
            |=> o_cmd.accel_set == $past(i_req.wdata[DCO_CW_ACC_LSB +: 2]);
    endproperty
    a_accel_take: assert property (p_accel_take) else $error("Accel set not taken");  // RULE2

    property p_step_take;
        @(posedge i_clk_sys) disable iff (i_reset)
        wr_word && i_req.wdata[DCO_CW_SEL_EN]
            |=> o_cmd.speed_step == $past(i_req.wdata[DCO_CW_STEP_LSB +: 4]);
    endproperty
    a_step_take: assert property (p_step_take) else $error("Speed step not taken");  // RULE3

    property p_sel_gate;
        @(posedge i_clk_sys) disable iff (i_reset)
        wr_word && !i_req.wdata[DCO_CW_SEL_EN] |=> $stable(o_cmd.accel_set) && $stable(o_cmd.speed_step);
    endproperty
    a_sel_gate: assert property (p_sel_gate) else $error("Selection changed while disabled");  // RULE4

    property p_src_toggle;
        @(posedge i_clk_sys) disable iff (i_reset)
        wr_word && (i_req.wdata[DCO_CW_SRC_LSB +: 2] == DCO_SRC_TOGGLE)
            |=> o_cmd.keypad_src != $past(o_cmd.keypad_src);
    endproperty
    a_src_toggle: assert property (p_src_toggle) else $error("Source did not toggle");  // RULE5

    property p_freq_back;
        @(posedge i_clk_sys) disable iff (i_reset)
        s_freq_written ##0 rd_freq |-> s_freq_read ##0 (o_rsp.rdata == $past(i_req.wdata, 4));
    endproperty
    a_freq_back: assert property (p_freq_back) else $error("Speed reference readback wrong");  // RULE6

    property p_trigger;
        @(posedge i_clk_sys) disable iff (i_reset)
        wr_trig |=> (o_cmd.ext_fault == $past(i_req.wdata[DCO_TR_EXT_FAULT]))
                    && (o_cmd.fault_reset == $past(i_req.wdata[DCO_TR_RESET]))
                    && (o_cmd.base_block == $past(i_req.wdata[DCO_TR_BLOCK]));
    endproperty
    a_trigger: assert property (p_trigger) else $error("Trigger bits not applied");  // RULE7

    property p_state_word;
        @(posedge i_clk_sys) disable iff (i_reset)
        rd_state && $past(!i_reset) |=> (o_rsp.rdata[DCO_SW_RUN_LSB +: 2] == $past(i_drv.run_state, 2))
            && (o_rsp.rdata[DCO_SW_DIR_LSB +: 2] == $past(i_drv.dir_state, 2))
            && (o_rsp.rdata[DCO_SW_FREQ_COMM] == $past(i_drv.freq_comm, 2))
            && (o_rsp.rdata[DCO_SW_FREQ_ANA] == $past(i_drv.freq_analog, 2));
    endproperty
    a_state_word: assert property (p_state_word) else $error("State word fields wrong");  // RULE8

    property p_run_cmd;
        @(posedge i_clk_sys) disable iff (i_reset)
        wr_word |=> o_cmd.strobe && (o_cmd.run == $past(i_req.wdata[DCO_CW_RUN_LSB +: 2]));
    endproperty
    a_run_cmd: assert property (p_run_cmd) else $error("Run command not applied");  // RULE12
endmodule : dco_object_decoder
`default_nettype wire

// >>> tb/dco_master_model.sv
`default_nettype none
module dco_master_model
    import dco_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire dco_rsp_type i_rsp,
    output var  dco_req_type o_req
);
    timeunit 1ns;
    timeprecision 1ns;
    initial o_req = '0;
    // One request at a time, valid for one edge, lines inverted when idle
    task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                          input logic [15:0] wd, output dco_rsp_type rsp, output int lat);
        lat = 0;
        rsp = '0;
        @(posedge i_clk_sys);
        o_req <= '{valid: 1'b1, write: wr, index: idx, sub: sub, wdata: wd};
        @(posedge i_clk_sys);
        o_req <= '{valid: 1'b0, write: ~wr, index: ~idx, sub: ~sub, wdata: ~wd};
        while (lat < 40 && rsp.valid !== 1'b1) begin
            @(posedge i_clk_sys);
            lat++;
            rsp = i_rsp;
        end
    endtask : access
endmodule : dco_master_model
`default_nettype wire

// >>> tb/dco_object_decoder_tb.sv
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module dco_object_decoder_tb
    import dco_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_clk_sys;
    logic        i_reset;
    dco_req_type req;
    dco_rsp_type par_rsp;
    dco_drv_type drv;
    dco_rsp_type rsp;
    dco_par_type par;
    dco_cmd_type cmd;
    dco_par_type par_seen;
    dco_rsp_type r;
    int          lat;
    int          par_dly;
    int          error_cnt;
    int          total_checks;

    dco_object_decoder u_dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_req(req), .i_par_rsp(par_rsp),
                              .i_drv(drv), .o_rsp(rsp), .o_par(par), .o_cmd(cmd));
    dco_master_model u_mst (.i_clk_sys(i_clk_sys), .i_rsp(rsp), .o_req(req));

    initial begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end

    // Parameter store stand-in, answers after par_dly edges
    initial begin
        forever begin
            @(posedge i_clk_sys);
            if (par.valid === 1'b1) begin
                par_seen = par;
                repeat (par_dly) @(posedge i_clk_sys);
                par_rsp <= '{valid: 1'b1, ok: 1'b1, rdata: {3'h0, par_seen.group, par_seen.member}};
                @(posedge i_clk_sys);
                par_rsp <= '{valid: 1'b0, ok: 1'b0, rdata: ~{3'h0, par_seen.group, par_seen.member}};
            end
        end
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run

    task automatic acc(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                       input logic [15:0] wd, input logic ok);
        u_mst.access(wr, idx, sub, wd, r, lat);
        if (r.valid !== 1'b1) begin
            error_cnt++;
            complete_run();
        end
        `CHK(r.ok, ok)
    endtask : acc

    task automatic t_local;
        acc(1'b0, DCO_CTL_INDEX, DCO_SUB_COUNT, 16'h0000, 1'b1);
        `CHK(r.rdata[7:0], DCO_CTL_COUNT_RST)
        `CHK(lat, 1)
        acc(1'b0, DCO_STS_INDEX, DCO_SUB_COUNT, 16'h0000, 1'b1);
        `CHK(r.rdata[7:0], DCO_STS_COUNT_RST)
        acc(1'b0, DCO_CTL_INDEX, DCO_SUB_FREQ, 16'h0000, 1'b1);
        `CHK(r.rdata, 16'h0000)
        acc(1'b1, DCO_STS_INDEX, DCO_SUB_STATE, 16'h1234, 1'b0);
        acc(1'b1, DCO_CTL_INDEX, DCO_SUB_COUNT, 16'h0005, 1'b0);
        acc(1'b0, 16'h2030, 8'h01, 16'h0000, 1'b0);
    endtask : t_local

    task automatic t_command;
        logic [15:0] w;
        logic        kp;
        kp = 1'b0;
        for (int k = 0; k < 4; k++) begin
            w = {1'b0, 2'(k), 1'b1, 4'(k * 5), 2'(k), 2'(k), 2'b00, 2'(k)};
            acc(1'b1, DCO_CTL_INDEX, DCO_SUB_CTL_WORD, w, 1'b1);
            kp = (k == 1) ? 1'b1 : (k == 2) ? 1'b0 : (k == 3) ? ~kp : kp;
            `CHK(cmd.strobe, 1'b1)
            `CHK({cmd.run, cmd.dir}, {2'(k), 2'(k)})
            `CHK(cmd.accel_set, 2'(k))
            `CHK(cmd.speed_step, 4'(k * 5))
            `CHK(cmd.keypad_src, kp)
        end
        @(posedge i_clk_sys);
        `CHK(cmd.strobe, 1'b0)
        acc(1'b1, DCO_CTL_INDEX, DCO_SUB_CTL_WORD, 16'h0012, 1'b1);
        `CHK({cmd.accel_set, cmd.speed_step}, 6'h3f)
        `CHK(cmd.keypad_src, kp)
        acc(1'b0, DCO_CTL_INDEX, DCO_SUB_CTL_WORD, 16'h0000, 1'b1);
        `CHK(r.rdata, 16'h0012)
    endtask : t_command

    task automatic t_freq_trig;
        acc(1'b1, DCO_CTL_INDEX, DCO_SUB_FREQ, 16'h03e8, 1'b1);
        `CHK(cmd.speed_ref, 16'h03e8)
        acc(1'b0, DCO_CTL_INDEX, DCO_SUB_FREQ, 16'h0000, 1'b1);
        `CHK(r.rdata, 16'h03e8)
        for (int b = 0; b < 3; b++) begin
            acc(1'b1, DCO_CTL_INDEX, DCO_SUB_TRIG, 16'(1 << b), 1'b1);
            `CHK({cmd.base_block, cmd.fault_reset, cmd.ext_fault}, 3'(1 << b))
        end
    endtask : t_freq_trig

    task automatic t_status;
        for (int k = 0; k < 4; k++) begin
            drv <= '{run_state: 2'(k), inch_run: k[0], dir_state: 2'(3 - k), freq_comm: k[1],
                     freq_analog: ~k[0], fault_code: 16'(16'h5a00 + k)};
            repeat (2) @(posedge i_clk_sys);
            acc(1'b0, DCO_STS_INDEX, DCO_SUB_STATE, 16'h0000, 1'b1);
            `CHK(r.rdata, {6'h00, ~k[0], k[1], 3'h0, 2'(3 - k), k[0], 2'(k)})
            acc(1'b0, DCO_STS_INDEX, DCO_SUB_FAULT, 16'h0000, 1'b1);
            `CHK(r.rdata, 16'(16'h5a00 + k))
        end
    endtask : t_status

    task automatic t_param;
        par_dly = 3;
        acc(1'b0, 16'h200a, 8'h10, 16'h0000, 1'b1);
        `CHK({par_seen.write, par_seen.group, par_seen.member}, {1'b0, 5'h0a, 8'h0f})
        `CHK(r.rdata, 16'h0a0f)
        par_dly = 0;
        acc(1'b1, 16'h201f, 8'h01, 16'h1234, 1'b1);
        `CHK({par_seen.write, par_seen.group, par_seen.member, par_seen.wdata}, {1'b1, 5'h1f, 8'h00, 16'h1234})
        acc(1'b0, 16'h2005, 8'h00, 16'h0000, 1'b0);
    endtask : t_param

    task automatic t_rerun;
        i_reset <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        i_reset <= 1'b0;
        @(posedge i_clk_sys);
        `CHK(cmd, '0)
        acc(1'b0, DCO_CTL_INDEX, DCO_SUB_FREQ, 16'h0000, 1'b1);
        `CHK(r.rdata, 16'h0000)
    endtask : t_rerun

    initial begin
        error_cnt = 0;
        total_checks = 0;
        par_dly = 0;
        i_reset = 1'b1;
        par_rsp = '0;
        drv = '0;
        repeat (2) @(posedge i_clk_sys);
        i_reset <= 1'b0;
        t_local();
        $display("t_local done");
        t_command();
        $display("t_command done");
        t_freq_trig();
        $display("t_freq_trig done");
        t_status();
        $display("t_status done");
        t_param();
        $display("t_param done");
        t_rerun();
        $display("t_rerun done");
        complete_run();
    end
endmodule : dco_object_decoder_tb
`default_nettype wire
